/* hw/sync_sel_pkg.sv */
/*
 * Constants and carrier types for the sync source selection block.
 * Assumes a 200 MHz pixel-rate clock and one AHB-Lite master.
 */
package sync_sel_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS = 8'h11;
    localparam logic [7:0] IDX_SELECT = 8'h12;
    localparam logic [7:0] IDX_THRESH = 8'h13;
    localparam logic [7:0] IDX_SCANPOL = 8'h14;
    localparam logic [7:0] IDX_POLSTAT = 8'h15;
    localparam logic [7:0] IDX_USERPOL = 8'h1e;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ST_HS_ACT = 7;
    localparam int ST_GREEN_ACT = 6;
    localparam int ST_VS_ACT = 5;
    localparam int ST_DIG_ACT = 4;
    localparam int ST_IF_USE = 3;
    localparam int ST_HS_CHOICE = 2;
    localparam int ST_VS_CHOICE = 1;
    localparam int SEL_IF_FORCE = 7;
    localparam int SEL_IF_PICK = 6;
    localparam int SEL_HS_FORCE = 5;
    localparam int SEL_HS_PICK = 4;
    localparam int SEL_VS_FORCE = 3;
    localparam int SEL_VS_PICK = 2;
    localparam int SEL_HOLD_SRC = 1;
    localparam int SEL_SLEEP_N = 0;
    localparam int SP_SCAN_EN = 2;
    localparam int SP_HOLD_POL_OVR = 1;
    localparam int SP_HS_POL_OVR = 0;
    localparam int PS_HS_POL = 7;
    localparam int UP_HOLD_POL = 1;
    localparam int UP_HS_POL = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SELECT = 8'h01;
    localparam logic [7:0] RST_THRESH = 8'h20;
    localparam logic [2:0] RST_SCANPOL = 3'h0;
    localparam logic [1:0] RST_USERPOL = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ACT_WINDOW_NS = 1000000;
    localparam int ACT_WINDOW_CYC = (ACT_WINDOW_NS * 1000) / CLK_PERIOD_PS;
    localparam int ACT_CNT_W = 18;
    localparam int POL_ACC_W = 12;

    // ------------------------------------------------------------
    // Pin indices and types
    // ------------------------------------------------------------
    localparam int NPIN = 7;
    localparam int P_HS = 0;
    localparam int P_VS = 1;
    localparam int P_GREEN = 2;
    localparam int P_HOLD = 3;
    localparam int P_DIG = 4;
    localparam int P_SCLK = 5;
    localparam int P_SIN = 6;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_st_t;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic hold;
        logic interface_in_use;
    } route_t;

    typedef struct packed {
        logic [NPIN-1:0][2:0] sy;
        logic [NPIN-1:0] lvl;
        logic [2:0][ACT_CNT_W-1:0] act_cnt;
        logic [2:0] act;
        logic dig_act;
        logic [1:0][POL_ACC_W-1:0] pol_acc;
        logic [1:0] pol_det;
        logic [7:0] sep_cnt;
        logic sep_out;
        logic [7:0] ctrl;
        logic [7:0] thr;
        logic [2:0] scanpol;
        logic [1:0] upol;
        logic ai;
        logic hsync_source_choice;
        logic vsync_source_choice;
        logic seek;
        route_t rt;
        logic hpol_o;
        logic cpol_o;
        logic [3:0] chain;
        bus_st_t bst;
        logic pwrite;
        logic [7:0] pidx;
        logic hready_o;
        logic [31:0] hrdata;
    } state_t;

endpackage

/* hw/sync_source_select.sv */
/*
 * Sync source selection, activity detection, sync separator, polarity
 * choice and scan chain, with registers on an AHB-Lite slave.
 * Assumes pins arrive asynchronously and a single-word AHB-Lite master.
 */
`timescale 1ns/1ps
module sync_source_select
    import sync_sel_pkg::*;
#(
    parameter int ACT_WINDOW = ACT_WINDOW_CYC
) (
    input wire logic clk, // 200 MHz pixel-rate clock
    input wire logic rst_n, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic [31:0] hrdata, // AHB read data
    output logic hresp, // AHB response, always OKAY
    input wire logic hsync_pin, // Hsync input pin
    input wire logic vsync_pin, // Vsync input pin
    input wire logic green_embedded_sync, // Sliced green sync
    input wire logic hold_pin, // Dedicated hold input pin
    input wire logic digital_clk_seen, // Digital clock activity
    input wire logic scan_clk, // Scan clock pin
    input wire logic scan_in, // Scan data in pin
    output logic scan_out, // Scan data out pin
    output logic hsync_out, // Routed horizontal sync
    output logic vsync_out, // Routed vertical sync
    output logic hold_out, // Routed hold to the PLL
    output logic interface_in_use, // Zero analog, one digital
    output logic seek_mode, // No interface active, interface choice not forced
    output logic hsync_pol, // Hsync polarity into the PLL
    output logic hold_pol, // Hold polarity into the PLL
    output logic full_sleep_n // Low powers interfaces down
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_q;
    logic rst_ok;
    state_t s_q;
    state_t s_d;
    logic [NPIN-1:0] pins;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_ok = rst_pipe_q[1];

    // Pin vector in index order
    assign pins = {scan_in, scan_clk, digital_clk_seen, hold_pin,
                   green_embedded_sync, vsync_pin, hsync_pin};

    // ------------------------------------------------------------
    // Register decode and readback
    // ------------------------------------------------------------
    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] idx, input state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_STATUS: begin
                v[ST_HS_ACT] = s.act[0];
                v[ST_GREEN_ACT] = s.act[2];
                v[ST_VS_ACT] = s.act[1];
                v[ST_DIG_ACT] = s.dig_act;
                v[ST_IF_USE] = s.ai;
                v[ST_HS_CHOICE] = s.hsync_source_choice;
                v[ST_VS_CHOICE] = s.vsync_source_choice;
            end
            IDX_SELECT: v = s.ctrl;
            IDX_THRESH: v = s.thr;
            IDX_SCANPOL: v = {5'h00, s.scanpol};
            IDX_POLSTAT: v[PS_HS_POL] = s.pol_det[0];
            IDX_USERPOL: v = {6'h00, s.upol};
            default: v = 8'h00;
        endcase
        reg_read = v;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [NPIN-1:0] edge_seen;
        logic sleep;
        logic analog_act;
        logic vs_route;
        logic sclk_rise;
        edge_seen = '0;
        sleep = 1'b0;
        analog_act = 1'b0;
        vs_route = 1'b0;
        sclk_rise = 1'b0;
        s_d = s_q;

        // Three-stage pin capture; level moves once stages two and three agree
        for (int i = 0; i < NPIN; i++) begin
            s_d.sy[i] = {s_q.sy[i][1:0], pins[i]};
            if (s_q.sy[i][1] == s_q.sy[i][2]) begin
                s_d.lvl[i] = s_q.sy[i][2];
            end
            edge_seen[i] = s_d.lvl[i] != s_q.lvl[i];
        end

        sleep = !s_q.ctrl[SEL_SLEEP_N];

        // Activity windows for hsync, vsync and green inputs
        for (int i = 0; i < 3; i++) begin
            if (sleep) begin
                s_d.act[i] = 1'b0;
                s_d.act_cnt[i] = '0;
            end else if (edge_seen[i]) begin
                s_d.act[i] = 1'b1;
                s_d.act_cnt[i] = '0;
            end else if (s_q.act_cnt[i] >= ACT_CNT_W'(ACT_WINDOW - 1)) begin
                s_d.act[i] = 1'b0; // Steady level counts as idle
            end else begin
                s_d.act_cnt[i] = s_q.act_cnt[i] + 1'b1;
            end
        end
        s_d.dig_act = s_q.lvl[P_DIG] && !sleep;

        // Polarity detectors: hsync pin (0) and hold pin (1)
        for (int i = 0; i < 2; i++) begin
            if (edge_seen[i * P_HOLD] && s_d.lvl[i * P_HOLD]) begin
                s_d.pol_det[i] = s_q.pol_acc[i][POL_ACC_W-1]; // Mostly low: positive
                s_d.pol_acc[i] = '0;
            end else if (s_q.lvl[i * P_HOLD]) begin
                if (s_q.pol_acc[i] != {1'b0, {(POL_ACC_W-1){1'b1}}}) begin
                    s_d.pol_acc[i] = s_q.pol_acc[i] + 1'b1;
                end
            end else if (s_q.pol_acc[i] != {1'b1, {(POL_ACC_W-1){1'b0}}}) begin
                s_d.pol_acc[i] = s_q.pol_acc[i] - 1'b1;
            end
        end

        // Sync separator on the green composite sync
        if (s_q.lvl[P_GREEN] == s_q.sep_out) begin
            s_d.sep_cnt = 8'h00;
        end else if (s_q.sep_cnt >= s_q.thr) begin
            s_d.sep_out = !s_q.sep_out;
            s_d.sep_cnt = 8'h00;
        end else begin
            s_d.sep_cnt = s_q.sep_cnt + 8'h01;
        end

        // Hsync choice
        if (s_q.ctrl[SEL_HS_FORCE]) begin
            s_d.hsync_source_choice = s_q.ctrl[SEL_HS_PICK];
        end else if (s_q.act[0] != s_q.act[2]) begin
            s_d.hsync_source_choice = s_q.act[2];
        end else begin
            s_d.hsync_source_choice = s_q.ctrl[SEL_HS_PICK];
        end

        // Vsync choice
        if (s_q.ctrl[SEL_VS_FORCE]) begin
            s_d.vsync_source_choice = s_q.ctrl[SEL_VS_PICK];
        end else begin
            s_d.vsync_source_choice = !s_q.act[1];
        end

        // Interface choice; keep last one while seeking
        analog_act = |s_q.act;
        s_d.seek = 1'b0;
        if (s_q.ctrl[SEL_IF_FORCE]) begin
            s_d.ai = s_q.ctrl[SEL_IF_PICK];
        end else if (analog_act && s_q.dig_act) begin
            s_d.ai = s_q.ctrl[SEL_IF_PICK];
        end else if (analog_act || s_q.dig_act) begin
            s_d.ai = s_q.dig_act;
        end else begin
            s_d.seek = 1'b1;
        end

        // Routing of sync and hold sources
        vs_route = s_q.vsync_source_choice ? s_q.sep_out : s_q.lvl[P_VS];
        s_d.rt.hsync = s_q.hsync_source_choice ? s_q.lvl[P_GREEN] : s_q.lvl[P_HS];
        s_d.rt.vsync = vs_route;
        s_d.rt.hold = s_q.ctrl[SEL_HOLD_SRC] ? vs_route : s_q.lvl[P_HOLD];
        s_d.rt.interface_in_use = s_q.ai;

        // Polarity applied to the PLL
        s_d.hpol_o = s_q.scanpol[SP_HS_POL_OVR] ? s_q.upol[UP_HS_POL]
                                                : s_q.pol_det[0];
        s_d.cpol_o = s_q.scanpol[SP_HOLD_POL_OVR] ? s_q.upol[UP_HOLD_POL]
                                                  : s_q.pol_det[1];

        // Scan chain replaces the routed outputs while enabled
        sclk_rise = edge_seen[P_SCLK] && s_d.lvl[P_SCLK];
        if (s_q.scanpol[SP_SCAN_EN]) begin
            if (sclk_rise) begin
                s_d.chain = {s_q.chain[2:0], s_q.lvl[P_SIN]};
            end
            s_d.rt = s_d.chain;
        end

        // Bus slave: address phase, then one wait state, then data
        case (s_q.bst)
            BUS_IDLE: begin
                if (hsel && htrans[1] && hready) begin
                    s_d.bst = BUS_DATA;
                    s_d.pwrite = hwrite;
                    s_d.pidx = word_index(haddr);
                    s_d.hready_o = 1'b0;
                end
            end
            BUS_DATA: begin
                s_d.bst = BUS_IDLE;
                s_d.hready_o = 1'b1;
                s_d.hrdata = 32'h0;
                if (s_q.pwrite) begin
                    case (s_q.pidx)
                        IDX_SELECT: s_d.ctrl = hwdata[7:0];
                        IDX_THRESH: s_d.thr = hwdata[7:0];
                        IDX_SCANPOL: s_d.scanpol = hwdata[2:0];
                        IDX_USERPOL: s_d.upol = hwdata[1:0];
                        default: s_d.hrdata = 32'h0;
                    endcase
                end else begin
                    s_d.hrdata = {24'h0, reg_read(s_q.pidx, s_q)};
                end
            end
            default: begin
                s_d.bst = BUS_IDLE;
                s_d.hready_o = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            s_q <= '0;
            s_q.ctrl <= RST_SELECT;
            s_q.thr <= RST_THRESH;
            s_q.scanpol <= RST_SCANPOL;
            s_q.upol <= RST_USERPOL;
            s_q.bst <= BUS_IDLE;
            s_q.hready_o <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register, except hresp tied to zero
    assign hreadyout = s_q.hready_o;
    assign hrdata = s_q.hrdata;
    assign hresp = 1'b0;
    assign scan_out = s_q.chain[3];
    assign hsync_out = s_q.rt.hsync;
    assign vsync_out = s_q.rt.vsync;
    assign hold_out = s_q.rt.hold;
    assign interface_in_use = s_q.rt.interface_in_use;
    assign seek_mode = s_q.seek;
    assign hsync_pol = s_q.hpol_o;
    assign hold_pol = s_q.cpol_o;
    assign full_sleep_n = s_q.ctrl[SEL_SLEEP_N];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_ok);

    hs_auto_a: assert property (!s_q.ctrl[5] && s_q.act[0] && !s_q.act[2] |=> !s_q.hsync_source_choice)
        else $error("hsync auto choice not pin");
    hs_tie_a: assert property (!s_q.ctrl[5] && (s_q.act[0] == s_q.act[2])
        |=> s_q.hsync_source_choice == $past(s_q.ctrl[4]))
        else $error("hsync tie not from select bit");
    hs_force_a: assert property (s_q.ctrl[5] |=> s_q.hsync_source_choice == $past(s_q.ctrl[4]))
        else $error("hsync override ignored");
    hs_route_a: assert property (!s_q.scanpol[2] && !$past(s_q.scanpol[2])
        |-> hsync_out == ($past(s_q.hsync_source_choice) ? $past(s_q.lvl[2]) : $past(s_q.lvl[0])))
        else $error("hsync routed from wrong source");
    vs_auto_a: assert property (!s_q.ctrl[3] |=> s_q.vsync_source_choice == !$past(s_q.act[1]))
        else $error("vsync auto choice wrong");
    vs_force_a: assert property (s_q.ctrl[3] |=> s_q.vsync_source_choice == $past(s_q.ctrl[2]))
        else $error("vsync override ignored");
    if_force_a: assert property (s_q.ctrl[7] |=> s_q.ai == $past(s_q.ctrl[6]))
        else $error("interface override ignored");
    sleep_quiet_a: assert property (!s_q.ctrl[0] |=> s_q.act == 3'h0 && !s_q.dig_act)
        else $error("activity reported while asleep");
    sep_toggle_a: assert property ($changed(s_q.sep_out)
        |-> $past(s_q.sep_cnt) >= $past(s_q.thr))
        else $error("separator toggled before threshold");
    pol_apply_a: assert property (s_q.scanpol[0] ##1 s_q.scanpol[0]
        |-> hsync_pol == $past(s_q.upol[0]))
        else $error("hsync polarity override ignored");
    idle_drop_a: assert property (s_q.ctrl[0] && s_q.act[0] && s_d.lvl[0] == s_q.lvl[0]
        && s_q.act_cnt[0] >= ACT_CNT_W'(ACT_WINDOW - 1) |=> !s_q.act[0])
        else $error("steady hsync still active");

    // Routing, interface, scan, activity, separator and polarity paths
    vs_route_a: assert property (!$past(s_q.scanpol[SP_SCAN_EN])
        |-> vsync_out == ($past(s_q.vsync_source_choice) ? $past(s_q.sep_out) : $past(s_q.lvl[P_VS])))
        else $error("vsync routed from wrong source");
    hold_route_a: assert property (!$past(s_q.scanpol[SP_SCAN_EN])
        |-> hold_out == ($past(s_q.ctrl[SEL_HOLD_SRC]) ? vsync_out : $past(s_q.lvl[P_HOLD])))
        else $error("hold routed from wrong source");
    if_auto_a: assert property (!s_q.ctrl[SEL_IF_FORCE] && ((|s_q.act) != s_q.dig_act)
        |=> s_q.ai == $past(s_q.dig_act))
        else $error("interface auto choice wrong");
    if_tie_a: assert property (!s_q.ctrl[SEL_IF_FORCE] && (|s_q.act) && s_q.dig_act
        |=> s_q.ai == $past(s_q.ctrl[SEL_IF_PICK]))
        else $error("interface tie not from pick bit");
    scan_load_a: assert property ($past(s_q.scanpol[SP_SCAN_EN])
        |-> {hsync_out, vsync_out, hold_out, interface_in_use} == s_q.chain)
        else $error("scan chain not on outputs");
    green_act_a: assert property ($past(s_q.ctrl[SEL_SLEEP_N])
        && $changed(s_q.lvl[P_GREEN]) |-> s_q.act[2])
        else $error("green edge left activity clear");
    vs_act_a: assert property ($past(s_q.ctrl[SEL_SLEEP_N])
        && $changed(s_q.lvl[P_VS]) |-> s_q.act[1])
        else $error("vsync edge left activity clear");
    sep_hold_a: assert property (s_q.lvl[P_GREEN] == s_q.sep_out
        |=> $stable(s_q.sep_out))
        else $error("separator toggled without difference");
    hpol_det_a: assert property (!$past(s_q.scanpol[SP_HS_POL_OVR])
        |-> hsync_pol == $past(s_q.pol_det[0]))
        else $error("detected hsync polarity not applied");
    cpol_user_a: assert property ($past(s_q.scanpol[SP_HOLD_POL_OVR])
        |-> hold_pol == $past(s_q.upol[UP_HOLD_POL]))
        else $error("user hold polarity not applied");

    green_pick_c: cover property (!s_q.ctrl[5] && !s_q.act[0] && s_q.act[2] ##1 s_q.hsync_source_choice);
    seek_c: cover property (s_q.seek);
    scan_shift_c: cover property (s_q.scanpol[2] && $changed(s_q.chain));
    bus_read_c: cover property (s_q.bst == BUS_DATA && !s_q.pwrite);
    // Separator output rising on a long green pulse
    sep_rise_c: cover property ($rose(s_q.sep_out));

endmodule

/* sim/video_source_model.sv */
/*
 * Behavioural video source driving hsync, vsync and sliced green sync.
 * Assumes the bench picks which lines run and the levels of stopped lines.
 */
`timescale 1ns/1ps
module video_source_model (
    input wire logic clk, // Pixel-rate clock
    input wire logic [2:0] run, // Toggle enables: hsync, green, vsync
    input wire logic [2:0] idle_lvl, // Levels held while stopped
    input wire logic [3:0] hs_width, // Hsync high cycles per 16
    output logic hsync_pin, // Horizontal sync line
    output logic green_sync, // Sliced green sync line
    output logic vsync_pin // Vertical sync line
);
    logic [4:0] cnt_q = 5'h00;

    // ------------------------------------------------------------
    // Line period counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        cnt_q <= cnt_q + 5'h01;
    end

    // Stopped lines rest at a steady level, so they show no activity
    assign hsync_pin = run[0] ? (cnt_q[3:0] < hs_width) : idle_lvl[0];
    assign green_sync = run[1] ? cnt_q[3] : idle_lvl[1];
    assign vsync_pin = run[2] ? cnt_q[4] : idle_lvl[2];
endmodule

/* sim/tb.sv */
/*
 * Self-checking bench for the sync source selection block.
 * Assumes the design package and the video source model compile first.
 */
`timescale 1ns/1ps
module tb;
    import sync_sel_pkg::*;
    localparam int WIN = 64;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp, hold_pin, digital_clk_seen;
    logic scan_clk, scan_in, scan_out, hsync_out, vsync_out, hold_out, hsync_pin;
    logic vsync_pin, green_sync, interface_in_use, seek_mode, hsync_pol, hold_pol;
    logic full_sleep_n, ai_exp;
    logic [31:0] haddr, hwdata, hrdata, rd, rnd;
    logic [1:0] htrans;
    logic [2:0] hsize, run, idle_lvl;
    logic [3:0] hs_width;
    logic [9:0] r;
    logic [7:0] exp_st;
    logic [9:0] corner [4] = '{10'h003, 10'h02b, 10'h30f, 10'h0c4};
    integer seed, bad_count, comparisons;

    // ------------------------------------------------------------
    // Clock, design and source model
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    sync_source_select #(.ACT_WINDOW(WIN)) sync_source_select_inst (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hsync_pin(hsync_pin),
        .vsync_pin(vsync_pin), .green_embedded_sync(green_sync), .hold_pin(hold_pin),
        .digital_clk_seen(digital_clk_seen), .scan_clk(scan_clk), .scan_in(scan_in),
        .scan_out(scan_out), .hsync_out(hsync_out), .vsync_out(vsync_out),
        .hold_out(hold_out), .interface_in_use(interface_in_use), .seek_mode(seek_mode),
        .hsync_pol(hsync_pol), .hold_pol(hold_pol), .full_sleep_n(full_sleep_n));

    video_source_model video_source_model_inst (.clk(clk), .run(run), .idle_lvl(idle_lvl),
        .hs_width(hs_width), .hsync_pin(hsync_pin), .green_sync(green_sync),
        .vsync_pin(vsync_pin));

    // ------------------------------------------------------------
    // Shared tasks and expectations
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single-word transfer; waits for hready in both phases
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        haddr <= {22'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        check({31'h0, n >= 50}, 32'h0);
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        check(rd, {24'h0, e});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Status bits 7..1 and seek flag in bit 0
    function automatic logic [7:0] exp_status(input logic [9:0] s, input logic prev);
        logic a;
        logic ai;
        a = s[0] | s[1] | s[2];
        if (s[8] || (a && s[3]))
            ai = s[9];
        else if (a || s[3])
            ai = s[3];
        else
            ai = prev;
        return {s[0], s[1], s[2], s[3], ai, s[4] ? s[5] : ((s[0] ^ s[1]) ? s[1] : s[5]),
            s[6] ? s[7] : ~s[2], ~(a | s[3]) & ~s[8]};
    endfunction

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #400000;
        bad_count++;
        conclude;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 53608;
        bad_count = 0;
        comparisons = 0;
        ai_exp = 1'b0;
        {rst_n, hwrite, hold_pin, digital_clk_seen, scan_clk, scan_in} = 6'h00;
        {haddr, hwdata, htrans, run, idle_lvl} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        hs_width = 4'h8;
        wait_cyc(20);
        rst_n <= 1'b1;
        wait_cyc(4);
        rchk(8'h12, 8'h01);
        rchk(8'h13, 8'h20);
        rchk(8'h14, 8'h00);
        wreg(8'h10, 8'hff);
        rchk(8'h10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            wreg(8'h13, rnd[7:0]);
            rchk(8'h13, rnd[7:0]);
        end
        $display("test registers finished");
        // Random activity and override mix, corners first
        for (int i = 0; i < 60; i++) begin
            rnd = $random(seed);
            r = (i < 4) ? corner[i] : rnd[9:0];
            run <= r[2:0];
            digital_clk_seen <= r[3];
            wreg(8'h12, {r[8], r[9], r[4], r[5], r[6], r[7], 2'b01});
            wait_cyc(130);
            exp_st = exp_status(r, ai_exp);
            bus(1'b0, 8'h11, 8'h00);
            check({24'h0, rd[7:1]}, {24'h0, exp_st[7:1]});
            check({interface_in_use, seek_mode}, {exp_st[3], exp_st[0]});
            // Seek keeps the choice left while old activity fades out
            ai_exp = (|exp_st[7:5]) ? 1'b0 : (exp_st[4] | exp_st[3]);
        end
        $display("test choice finished");
        // Steady levels routed under override
        run <= 3'b000;
        digital_clk_seen <= 1'b0;
        idle_lvl <= 3'b101;
        wreg(8'h13, 8'h0c);
        wreg(8'h12, 8'h2b);
        wait_cyc(130);
        check({hsync_out, vsync_out, hold_out}, 32'h7);
        wreg(8'h12, 8'h3d);
        hold_pin <= 1'b1;
        wait_cyc(10);
        check({hsync_out, vsync_out, hold_out}, 32'h1);
        // Separator ignores a pulse shorter than the threshold
        idle_lvl <= 3'b111;
        wait_cyc(6);
        idle_lvl <= 3'b101;
        wait_cyc(30);
        check(vsync_out, 32'h0);
        idle_lvl <= 3'b111;
        wait_cyc(8);
        check(vsync_out, 32'h0);
        wait_cyc(22);
        check(vsync_out, 32'h1);
        hold_pin <= 1'b0;
        wreg(8'h12, 8'h3f);
        wait_cyc(10);
        check(hold_out, 32'h1);
        $display("test routing finished");
        // Full sleep hides activity
        run <= 3'b111;
        digital_clk_seen <= 1'b1;
        wreg(8'h12, 8'h00);
        wait_cyc(20);
        bus(1'b0, 8'h11, 8'h00);
        check({rd[7:4], full_sleep_n}, 32'h0);
        wreg(8'h12, 8'h01);
        wait_cyc(130);
        bus(1'b0, 8'h11, 8'h00);
        check({rd[7:4], full_sleep_n}, 32'h1f);
        $display("test sleep finished");
        // Detected hsync polarity, then user polarity under override
        run <= 3'b001;
        wreg(8'h14, 8'h00);
        for (int k = 0; k < 2; k++) begin
            hs_width <= (k == 0) ? 4'h2 : 4'he;
            wait_cyc(9000);
            bus(1'b0, 8'h15, 8'h00);
            check({rd[7], hsync_pol}, (k == 0) ? 32'h3 : 32'h0);
        end
        wreg(8'h14, 8'h03);
        rchk(8'h14, 8'h03);
        for (int j = 0; j < 4; j++) begin
            rnd = $random(seed);
            wreg(8'h1e, {6'h00, rnd[1:0]});
            wait_cyc(10);
            check({hold_pol, hsync_pol}, rnd[1:0]);
        end
        $display("test polarity finished");
        // Scan chain shifts four bits through to scan out
        wreg(8'h14, 8'h04);
        rnd = $random(seed);
        for (int i = 0; i < 4; i++) begin
            scan_in <= rnd[i];
            wait_cyc(8);
            scan_clk <= 1'b1;
            wait_cyc(8);
            scan_clk <= 1'b0;
        end
        wait_cyc(8);
        exp_st = {4'h0, rnd[0], rnd[1], rnd[2], rnd[3]};
        check(scan_out, rnd[0]);
        check({hsync_out, vsync_out, hold_out, interface_in_use}, exp_st);
        $display("test scan finished");
        conclude;
    end
endmodule
